// *** design/sclp_slave.sv ***
// Function
// - Up to 240 individual slave addresses
// - Separate data and clock lines each way
// - Start and stop: data edge, clock high
// - Nine-bit words, one missing clock between
// - Bits go least significant first
// - Top bit flags the last word
// - Header: address, sub-address, control word
// - Control: read/write and internal/external bits
// - Header checksum is XOR of nibbles
// - Zero to 256 data words follow header
// - Trailer holds XOR of data bytes
// - Accept individual or partial broadcast address
// - Interrupt frame is own address, flagged last
// - Good write applied silently
// - Checksum error answered by interrupt frame
// - Wait for idle up line, then wait
// - Long activity timeout resets state machines
// - Read count register, returns count plus one
// - Read reply echoes the request header
// - User interrupt seizes bus unprompted
// - Header error discards frame, raises interrupt
// - Trailer error still applies the data
// - Interrupt cause kept in a register
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module sclp_slave #(
  parameter int TIMEOUT_LIMIT = sclp_pkg::TIMEOUT_CYCLES
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic down_clock_line,
  input wire logic down_data_line,
  input wire logic up_clock_sense,
  input wire logic up_data_sense,
  output logic up_clock_line,
  output logic up_data_line,
  output logic up_line_oe
);
  import sclp_pkg::*;

  localparam int PW = $clog2(BIT_CYCLES);
  localparam logic [PW-1:0] PH_END = PW'(BIT_CYCLES - 1);
  localparam logic [PW-1:0] PH_HALF = PW'(HALF_CYCLES);

  logic [1:0] dclk_s, ddat_s, uclk_s, udat_s;
  logic dclk_q, ddat_q, uclk_q, udat_q;
  logic up_busy, tout;
  logic [31:0] tout_cnt;
  sclp_cfg_t cfg;
  logic [2:0] cause;
  logic [7:0] reply_byte, wc;
  logic [7:0] res_data, res_sub;
  logic [8:0] res_cnt;
  logic res_int;
  logic irq_pend, reply_pend;
  logic rx_busy, got_last, trl_ok, hdr_ok, match, ind;
  logic [3:0] bit_cnt;
  logic [8:0] sh, widx, dcount;
  logic [7:0] dxor, first_byte, last_byte;
  sclp_hdr_t hdr, rep_hdr;
  logic ev_hdr, ev_trl, ev_commit, ev_reply;
  sclp_tx_state_t tx_state;
  logic [PW-1:0] ph;
  logic [1:0] wait_left;
  logic [3:0] bitn;
  logic [8:0] tx_idx;
  logic [7:0] tx_xor, tx_byte;
  logic tx_is_irq;
  sclp_word_t tx_word, word;

  // Two-stage synchronisers, third stage only for edge finding
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dclk_s <= 2'h3;
      ddat_s <= 2'h3;
      uclk_s <= 2'h3;
      udat_s <= 2'h3;
      dclk_q <= 1'b1;
      ddat_q <= 1'b1;
      uclk_q <= 1'b1;
      udat_q <= 1'b1;
    end
    else
    begin
      dclk_s <= {dclk_s[0], down_clock_line};
      ddat_s <= {ddat_s[0], down_data_line};
      uclk_s <= {uclk_s[0], up_clock_sense};
      udat_s <= {udat_s[0], up_data_sense};
      dclk_q <= dclk_s[1];
      ddat_q <= ddat_s[1];
      uclk_q <= uclk_s[1];
      udat_q <= udat_s[1];
    end
  end

  // Clock held high across both samples rejects skew glitches
  wire d_rise = dclk_s[1] & ~dclk_q;
  wire d_start = dclk_s[1] & dclk_q & ~ddat_s[1] & ddat_q;
  wire d_stop = dclk_s[1] & dclk_q & ddat_s[1] & ~ddat_q;
  wire u_start = uclk_s[1] & uclk_q & ~udat_s[1] & udat_q;
  wire u_stop = uclk_s[1] & uclk_q & udat_s[1] & ~udat_q;

  // Up line watcher for arbitration
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      up_busy <= 1'b0;
    else if (tout)
      up_busy <= 1'b0;
    else if (u_start)
      up_busy <= 1'b1;
    else if (u_stop)
      up_busy <= 1'b0;
  end

  // Any frame longer than the longest legal one is abandoned
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tout_cnt <= '0;
      tout <= 1'b0;
    end
    else
    begin
      tout <= (rx_busy | up_busy) && tout_cnt == 32'(TIMEOUT_LIMIT - 1);
      if (!(rx_busy | up_busy) || tout)
        tout_cnt <= '0;
      else
        tout_cnt <= tout_cnt + 32'd1;
    end
  end

  // Receiver
  assign word = {ddat_s[1], sh[8:1]};
  wire word_done = rx_busy && d_rise && bit_cnt == 4'd8;
  wire [3:0] hdr_sum = hdr.addr[3:0] ^ hdr.addr[7:4] ^ hdr.sub[3:0]
    ^ hdr.sub[7:4] ^ word.data[7:4];
  wire hit_ind = word.data == cfg.own;
  wire hit_bc = word.data[7:4] == BCAST_PREFIX
    && word.data[3:0] == cfg.bcast;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_busy <= 1'b0;
      bit_cnt <= '0;
      sh <= '0;
      widx <= '0;
      hdr <= '0;
      rep_hdr <= '0;
      dxor <= '0;
      dcount <= '0;
      first_byte <= '0;
      last_byte <= '0;
      got_last <= 1'b0;
      trl_ok <= 1'b0;
      hdr_ok <= 1'b0;
      match <= 1'b0;
      ind <= 1'b0;
      wc <= '0;
      ev_hdr <= 1'b0;
      ev_trl <= 1'b0;
      ev_commit <= 1'b0;
      ev_reply <= 1'b0;
    end
    else
    begin
      ev_hdr <= 1'b0;
      ev_trl <= 1'b0;
      ev_commit <= 1'b0;
      ev_reply <= 1'b0;
      if (tout)
        rx_busy <= 1'b0;
      else if (d_start)
      begin
        rx_busy <= 1'b1;
        bit_cnt <= '0;
        widx <= '0;
        dxor <= '0;
        dcount <= '0;
        got_last <= 1'b0;
        hdr_ok <= 1'b0;
        match <= 1'b0;
      end
      else if (d_stop && rx_busy)
      begin
        rx_busy <= 1'b0;
        // Short or unflagged frames fall through untouched
        if (match && hdr_ok && got_last)
        begin
          if (!trl_ok)
            ev_trl <= 1'b1;
          if (!hdr.ctrl[CTRL_RW_BIT])
            ev_commit <= dcount != 9'd0;
          else if (trl_ok && ind && dcount != 9'd0)
          begin
            ev_reply <= 1'b1;
            wc <= first_byte;
            rep_hdr <= hdr;
          end
        end
      end
      else if (rx_busy && d_rise)
      begin
        sh <= {ddat_s[1], sh[8:1]};
        bit_cnt <= bit_cnt == 4'd8 ? 4'd0 : bit_cnt + 4'd1;
        if (word_done && !got_last)
        begin
          widx <= widx + 9'd1;
          got_last <= word.last && widx >= 9'(HDR_WORDS);
          case (widx)
            9'd0:
            begin
              hdr.addr <= word.data;
              match <= hit_ind | hit_bc;
              ind <= hit_ind;
            end
            9'd1:
              hdr.sub <= word.data;
            9'd2:
            begin
              hdr.ctrl <= word.data;
              hdr_ok <= hdr_sum == word.data[3:0];
              if (hdr_sum != word.data[3:0] && match)
                ev_hdr <= 1'b1;
            end
            default:
            begin
              if (word.last)
                trl_ok <= word.data == dxor;
              else if (dcount != 9'd256)
              begin
                dxor <= dxor ^ word.data;
                dcount <= dcount + 9'd1;
                last_byte <= word.data;
                if (dcount == 9'd0)
                  first_byte <= word.data;
              end
            end
          endcase
        end
      end
    end
  end

  // Bus slave: no wait states, answer registered at setup
  wire apb_wr = psel && penable && pready && pwrite;
  wire user_set = apb_wr && paddr == OFF_CMD && pwdata[CMD_USER_IRQ];
  wire tx_take = tx_state == TX_WAIT && !up_busy && ph == PH_END
    && wait_left == 2'd1;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= '0;
      if (psel && !penable)
      begin
        case (paddr)
          OFF_CONFIG:
            prdata <= {20'h0, cfg};
          OFF_CAUSE:
            prdata <= {29'h0, cause};
          OFF_CMD:
            prdata <= {31'h0, irq_pend};
          OFF_REPLY:
            prdata <= {24'h0, reply_byte};
          OFF_RESULT:
            prdata <= {6'h0, res_int, res_cnt, res_sub, res_data};
          OFF_STATUS:
            prdata <= {19'h0, tx_state != TX_IDLE, rx_busy, up_busy,
              reply_pend, irq_pend, wc};
          default:
            pslverr <= 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg <= {RST_BCAST, RST_OWN_ADDR};
      reply_byte <= RST_REPLY;
    end
    else if (apb_wr && paddr == OFF_CONFIG)
      cfg <= pwdata[11:0];
    else if (apb_wr && paddr == OFF_REPLY)
      reply_byte <= pwdata[7:0];
  end

  // Sticky causes, write one to clear, a new event beats the clear
  wire [2:0] cause_clr = (apb_wr && paddr == OFF_CAUSE) ? pwdata[2:0] : 3'h0;
  wire [2:0] cause_set = {user_set, ev_trl, ev_hdr};
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cause <= '0;
    else
      cause <= cause_set | (cause & ~cause_clr);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      res_data <= '0;
      res_sub <= '0;
      res_cnt <= '0;
      res_int <= 1'b0;
    end
    else if (ev_commit)
    begin
      res_data <= last_byte;
      res_sub <= hdr.sub;
      res_cnt <= dcount;
      res_int <= hdr.ctrl[CTRL_INT_BIT];
    end
  end

  // Pending transmissions, set wins over the take
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_pend <= 1'b0;
      reply_pend <= 1'b0;
    end
    else
    begin
      irq_pend <= ev_hdr | ev_trl | user_set
        | (irq_pend & ~(tx_take & tx_is_irq));
      reply_pend <= ev_reply | (reply_pend & ~(tx_take & ~tx_is_irq));
    end
  end

  // Word to send
  always_comb
  begin
    tx_word = '0;
    if (tx_is_irq)
      tx_word = {1'b1, cfg.own};
    else if (tx_idx == 9'd0)
      tx_word = {1'b0, rep_hdr.addr};
    else if (tx_idx == 9'd1)
      tx_word = {1'b0, rep_hdr.sub};
    else if (tx_idx == 9'd2)
      tx_word = {1'b0, rep_hdr.ctrl};
    else if (tx_idx <= {1'b0, wc} + 9'd3)
      tx_word = {1'b0, tx_byte};
    else
      tx_word = {1'b1, tx_xor};
  end

  // Transmitter, link clock divided from pclk
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_state <= TX_IDLE;
      ph <= '0;
      wait_left <= '0;
      bitn <= '0;
      tx_idx <= '0;
      tx_xor <= '0;
      tx_byte <= '0;
      tx_is_irq <= 1'b0;
      up_line_oe <= 1'b0;
      up_clock_line <= 1'b1;
      up_data_line <= 1'b1;
    end
    else if (tout)
    begin
      tx_state <= TX_IDLE;
      ph <= '0;
      up_line_oe <= 1'b0;
      up_clock_line <= 1'b1;
      up_data_line <= 1'b1;
    end
    else
    begin
      ph <= ph == PH_END ? '0 : ph + PW'(1);
      case (tx_state)
        TX_IDLE:
        begin
          ph <= '0;
          if ((irq_pend || reply_pend) && !up_busy)
          begin
            tx_state <= TX_WAIT;
            tx_is_irq <= irq_pend;
            // Shorter wait gives interrupts priority
            wait_left <= irq_pend ? 2'(IRQ_WAIT_BITS) : 2'(REPLY_WAIT_BITS);
          end
        end
        TX_WAIT:
          if (up_busy)
            tx_state <= TX_IDLE;
          else if (ph == PH_END)
          begin
            wait_left <= wait_left - 2'd1;
            if (wait_left == 2'd1)
            begin
              tx_state <= TX_START;
              up_line_oe <= 1'b1;
              up_clock_line <= 1'b1;
              up_data_line <= 1'b1;
              tx_idx <= '0;
              tx_xor <= '0;
              tx_byte <= reply_byte;
            end
          end
        TX_START:
        begin
          if (ph == PH_HALF)
            up_data_line <= 1'b0;
          if (ph == PH_END)
          begin
            tx_state <= TX_BIT;
            bitn <= '0;
          end
        end
        TX_BIT:
        begin
          if (ph == '0)
          begin
            up_clock_line <= 1'b0;
            up_data_line <= tx_word[bitn];
          end
          if (ph == PH_HALF)
            up_clock_line <= 1'b1;
          if (ph == PH_END)
          begin
            bitn <= bitn + 4'd1;
            if (bitn == 4'd8)
            begin
              if (!tx_word.last && tx_idx >= 9'(HDR_WORDS))
                tx_xor <= tx_xor ^ tx_word.data;
              tx_state <= tx_word.last ? TX_STOP : TX_GAP;
            end
          end
        end
        TX_GAP:
        begin
          if (ph == '0)
            up_clock_line <= 1'b0;
          if (ph == PH_END)
          begin
            tx_idx <= tx_idx + 9'd1;
            bitn <= '0;
            tx_state <= TX_BIT;
          end
        end
        TX_STOP:
        begin
          if (ph == '0)
          begin
            up_clock_line <= 1'b0;
            up_data_line <= 1'b0;
          end
          if (ph == PH_HALF)
            up_clock_line <= 1'b1;
          if (ph == PH_END)
          begin
            up_data_line <= 1'b1;
            tx_state <= TX_END;
          end
        end
        TX_END:
          if (ph == PH_END)
          begin
            up_line_oe <= 1'b0;
            tx_state <= TX_IDLE;
          end
        default:
          tx_state <= TX_IDLE;
      endcase
    end
  end

  sequence s_start_cond;
    up_data_line && up_clock_line ##[1:10] !up_data_line && up_clock_line;
  endsequence
  sequence s_gap;
    !up_clock_line [*8];
  endsequence

  property p_start_cond;
    @(posedge pclk) disable iff (!presetn)
      $rose(up_line_oe) |-> s_start_cond;
  endproperty
  a_start_cond: assert property (p_start_cond)
    else $error("no start condition at frame open");

  property p_arb_idle;
    @(posedge pclk) disable iff (!presetn)
      $rose(up_line_oe) |-> !$past(up_busy);
  endproperty
  a_arb_idle: assert property (p_arb_idle)
    else $error("up line seized while busy");

  property p_clk_high;
    @(posedge pclk) disable iff (!presetn)
      $rose(up_clock_line) && tx_state == TX_BIT
        |-> up_clock_line [*5] ##1 !up_clock_line;
  endproperty
  a_clk_high: assert property (p_clk_high)
    else $error("link clock high phase wrong");

  property p_gap;
    @(posedge pclk) disable iff (!presetn)
      tx_state == TX_GAP && ph == '0 |=> s_gap;
  endproperty
  a_gap: assert property (p_gap)
    else $error("missing clock cycle not held low");

  property p_bit_order;
    @(posedge pclk) disable iff (!presetn)
      tx_state == TX_BIT && ph == PH_HALF |-> up_data_line == tx_word[bitn];
  endproperty
  a_bit_order: assert property (p_bit_order)
    else $error("wrong bit on up data line");

  property p_irq_word;
    @(posedge pclk) disable iff (!presetn)
      tx_state == TX_BIT && tx_is_irq |-> tx_word == {1'b1, cfg.own};
  endproperty
  a_irq_word: assert property (p_irq_word)
    else $error("interrupt frame word wrong");

  property p_hdr_discard;
    @(posedge pclk) disable iff (!presetn)
      ev_hdr |-> !ev_commit ##1 cause[CAUSE_HDR] && irq_pend;
  endproperty
  a_hdr_discard: assert property (p_hdr_discard)
    else $error("header error not handled");

  property p_trl_apply;
    @(posedge pclk) disable iff (!presetn)
      ev_trl && !hdr.ctrl[CTRL_RW_BIT] && dcount != 9'd0
        |=> res_cnt == $past(dcount) && cause[CAUSE_TRL];
  endproperty
  a_trl_apply: assert property (p_trl_apply)
    else $error("trailer error lost data or cause");

  property p_timeout;
    @(posedge pclk) disable iff (!presetn)
      tout |=> !rx_busy && !up_busy && tx_state == TX_IDLE;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("timeout did not reset state");

endmodule
`default_nettype wire

// *** design/sclp_pkg.sv ***
package sclp_pkg;

  // Link timing
  localparam int CLK_HZ = 100_000_000;
  localparam int LINK_HZ = 10_000_000;
  localparam int BIT_CYCLES = CLK_HZ / LINK_HZ;
  localparam int HALF_CYCLES = BIT_CYCLES / 2;
  localparam int TIMEOUT_US = 300;
  localparam int TIMEOUT_CYCLES = TIMEOUT_US * (CLK_HZ / 1_000_000);
  localparam int IRQ_WAIT_BITS = 1;
  localparam int REPLY_WAIT_BITS = 2;

  // Frame layout
  localparam int WORD_LAST_BIT = 8;
  localparam int HDR_WORDS = 3;
  localparam int CTRL_RW_BIT = 7;
  localparam int CTRL_INT_BIT = 6;
  localparam logic [3:0] BCAST_PREFIX = 4'hF;

  // Register offsets
  localparam logic [7:0] OFF_CONFIG = 8'h00;
  localparam logic [7:0] OFF_CAUSE = 8'h04;
  localparam logic [7:0] OFF_CMD = 8'h08;
  localparam logic [7:0] OFF_REPLY = 8'h0C;
  localparam logic [7:0] OFF_RESULT = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;

  // Field positions
  localparam int CAUSE_HDR = 0;
  localparam int CAUSE_TRL = 1;
  localparam int CAUSE_USER = 2;
  localparam int CMD_USER_IRQ = 0;

  // Values after reset
  localparam logic [7:0] RST_OWN_ADDR = 8'h01;
  localparam logic [3:0] RST_BCAST = 4'h0;
  localparam logic [7:0] RST_REPLY = 8'h00;

  typedef struct packed {
    logic last;
    logic [7:0] data;
  } sclp_word_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] sub;
    logic [7:0] ctrl;
  } sclp_hdr_t;

  typedef struct packed {
    logic [3:0] bcast;
    logic [7:0] own;
  } sclp_cfg_t;

  typedef enum {
    TX_IDLE, TX_WAIT, TX_START, TX_BIT, TX_GAP, TX_STOP, TX_END
  } sclp_tx_state_t;

endpackage

// *** bench/sclp_master_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module sclp_master_model
(
  input wire logic pclk,
  input wire logic up_clock_line,
  input wire logic up_data_line,
  output logic down_clock_line,
  output logic down_data_line
);
  logic [8:0] rx_q[$];
  int frames = 0;
  int n = 0;
  logic pc = 1'b1;
  logic pd = 1'b1;
  logic [8:0] sh = '0;

  initial
  begin
    down_clock_line = 1'b1;
    down_data_line = 1'b1;
  end

  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
  endtask

  // Link bit is 16 pclk (160 ns); lines rest high between frames
  task automatic send(input logic [8:0] q[$]);
    while (!(up_clock_line && up_data_line))
      tick(1);
    tick(48); // Three bit times, so slaves win the line
    down_data_line <= 1'b0; // Start with clock high
    tick(8);
    foreach (q[i])
    begin
      for (int b = 0; b < 9; b++)
      begin
        down_clock_line <= 1'b0;
        down_data_line <= q[i][b];
        tick(8);
        down_clock_line <= 1'b1;
        tick(8);
      end
      if (i < q.size() - 1)
      begin
        down_clock_line <= 1'b0; // Missing clock
        tick(16);
      end
    end
    down_clock_line <= 1'b0;
    down_data_line <= 1'b0;
    tick(8);
    down_clock_line <= 1'b1;
    tick(8);
    down_data_line <= 1'b1; // Stop with clock high
    tick(8);
  endtask

  // Stop bit adds one clock rise; the next start clears the count
  always @(posedge pclk)
  begin
    if (up_clock_line && pc && pd && !up_data_line)
      n = 0;
    else if (up_clock_line && pc && !pd && up_data_line)
      frames++;
    else if (up_clock_line && !pc)
    begin
      sh = {up_data_line, sh[8:1]};
      n++;
      if (n == 9)
      begin
        rx_q.push_back(sh);
        n = 0;
      end
    end
    pc = up_clock_line;
    pd = up_data_line;
  end
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import sclp_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, hil;
  logic dc, dd, ucl, udl, oe;
  logic [7:0] paddr, own, hs, rep, nn, x;
  logic [3:0] bc;
  logic [31:0] pwdata, prdata, r, res;
  logic [7:0] dq[$];
  logic [8:0] fq[$];
  logic [8:0] eq[$];
  wire logic uc;
  wire logic ud;
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int f0;

  // Up lines idle high when nobody drives them
  assign uc = oe ? ucl : 1'b1;
  assign ud = oe ? udl : 1'b1;

  sclp_slave #(.TIMEOUT_LIMIT(2000)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .down_clock_line(dc), .down_data_line(dd), .up_clock_sense(uc),
    .up_data_sense(ud), .up_clock_line(ucl), .up_data_line(udl),
    .up_line_oe(oe));

  sclp_master_model mdl (.pclk(pclk), .up_clock_line(uc), .up_data_line(ud),
    .down_clock_line(dc), .down_data_line(dd));

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task end_sim;
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      errors++;
      end_sim();
    end
  end

  task chk(input string nm, input logic [31:0] xp, input logic [31:0] got);
    n_compared++;
    if (got !== xp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, xp, got);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // No wait state count assumed; only the cycle ceiling ends a hang
    while (pready !== 1'b1)
      @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] xp, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, xp, r);
  endtask

  task rnd(input int n);
    dq.delete();
    repeat (n) dq.push_back(8'($urandom));
  endtask

  task mk(input logic [7:0] a, input logic rw, input logic bh, bt);
    logic [7:0] c;
    hs = 8'($urandom);
    hil = 1'($urandom);
    c = {rw, hil, 6'h00};
    c[3:0] = a[3:0] ^ a[7:4] ^ hs[3:0] ^ hs[7:4] ^ c[7:4] ^ {3'h0, bh};
    x = 8'h00;
    fq.delete();
    fq.push_back({1'b0, a});
    fq.push_back({1'b0, hs});
    fq.push_back({1'b0, c});
    foreach (dq[i])
    begin
      fq.push_back({1'b0, dq[i]});
      x ^= dq[i];
    end
    fq.push_back({1'b1, x ^ {7'h0, bt}});
  endtask

  task go;
    mdl.rx_q.delete();
    f0 = mdl.frames;
    mdl.send(fq);
    repeat (1500) @(posedge pclk);
  endtask

  task cmp_rx;
    chk("rx_len", 32'(eq.size()), 32'(mdl.rx_q.size()));
    foreach (eq[i])
      chk("rx_word", 32'(eq[i]), 32'(mdl.rx_q[i]));
  endtask

  task irq_eq;
    eq.delete();
    eq.push_back({1'b1, own});
  endtask

  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    presetn = 1'b0;
    void'($urandom(27));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rdc(OFF_CONFIG, {20'h0, RST_BCAST, RST_OWN_ADDR}, "config_rst");
    rdc(OFF_CAUSE, 32'h0, "cause_rst");
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, e});
    own = 8'h10 + 8'($urandom % 208);
    bc = 4'($urandom % 15);
    apb(1'b1, OFF_CONFIG, {20'h0, bc, own});
    rdc(OFF_CONFIG, {20'h0, bc, own}, "config");
    // Good write to own address answers nothing
    rnd(1 + $urandom % 4);
    mk(own, 1'b0, 1'b0, 1'b0);
    go();
    res = {6'h0, hil, 9'(dq.size()), hs, dq[dq.size() - 1]};
    chk("silent", 32'(f0), 32'(mdl.frames));
    rdc(OFF_RESULT, res, "result_own");
    rnd(1);
    mk({BCAST_PREFIX, bc}, 1'b0, 1'b0, 1'b0);
    go();
    res = {6'h0, hil, 9'(dq.size()), hs, dq[0]};
    rdc(OFF_RESULT, res, "result_bcast");
    rnd(2);
    mk(own ^ 8'h01, 1'b0, 1'b0, 1'b0);
    go();
    rdc(OFF_RESULT, res, "result_other");
    // Header checksum error: frame dropped, interrupt sent
    rnd(2);
    mk(own, 1'b0, 1'b1, 1'b0);
    go();
    irq_eq();
    chk("hdr_irq", 32'(f0 + 1), 32'(mdl.frames));
    cmp_rx();
    rdc(OFF_RESULT, res, "result_hdr");
    rdc(OFF_CAUSE, 32'(1) << CAUSE_HDR, "cause_hdr");
    apb(1'b1, OFF_CAUSE, 32'h7);
    rdc(OFF_CAUSE, 32'h0, "cause_clr");
    // Trailer error: data still applied
    rnd(3);
    mk(own, 1'b0, 1'b0, 1'b1);
    go();
    res = {6'h0, hil, 9'(dq.size()), hs, dq[2]};
    chk("trl_irq", 32'(f0 + 1), 32'(mdl.frames));
    cmp_rx();
    rdc(OFF_RESULT, res, "result_trl");
    rdc(OFF_CAUSE, 32'(1) << CAUSE_TRL, "cause_trl");
    apb(1'b1, OFF_CAUSE, 32'h7);
    // Read: reply echoes header, count plus one words
    rep = 8'($urandom);
    apb(1'b1, OFF_REPLY, {24'h0, rep});
    nn = 8'($urandom % 4);
    dq.delete();
    dq.push_back(nn);
    mk(own, 1'b1, 1'b0, 1'b0);
    go();
    eq.delete();
    for (int i = 0; i < 3; i++)
      eq.push_back(fq[i]);
    x = 8'h00;
    repeat (nn + 1)
    begin
      eq.push_back({1'b0, rep});
      x ^= rep;
    end
    eq.push_back({1'b1, x});
    chk("reply", 32'(f0 + 1), 32'(mdl.frames));
    cmp_rx();
    rdc(OFF_STATUS, {24'h0, nn}, "status_wc");
    // User interrupt seizes the line unprompted
    mdl.rx_q.delete();
    f0 = mdl.frames;
    apb(1'b1, OFF_CMD, 32'h1);
    repeat (600) @(posedge pclk);
    irq_eq();
    chk("user_irq", 32'(f0 + 1), 32'(mdl.frames));
    cmp_rx();
    rdc(OFF_CAUSE, 32'(1) << CAUSE_USER, "cause_user");
    // Frame stopped inside the header is dropped
    rnd(1);
    mk(own, 1'b0, 1'b0, 1'b0);
    fq = fq[0:1];
    go();
    chk("trunc", 32'(f0), 32'(mdl.frames));
    rdc(OFF_RESULT, res, "result_trunc");
    // Frame outliving the bench timeout limit is abandoned mid-way
    rnd(12);
    mk(own, 1'b0, 1'b0, 1'b0);
    go();
    chk("tout_silent", 32'(f0), 32'(mdl.frames));
    rdc(OFF_RESULT, res, "result_tout");
    rdc(OFF_STATUS, {24'h0, nn}, "status_tout");
    end_sim();
  end
endmodule
`default_nettype wire
